//--- design/adc_conv_ctrl.sv
/*
  Conversion clock divider, track/convert sequencer, result accumulator and
  its AXI4-Lite register file with a done interrupt. Assumes sar_done is a
  one-cycle pulse on aclk answering sar_start, and lp_osc_pin is asynchronous.
*/
`default_nettype none
module adc_conv_ctrl (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [11:0]                    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [11:0]                    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           lp_osc_pin,
  input  wire logic                           start_trigger,
  output logic                                sar_start,
  input  wire logic                           sar_done,
  input  wire logic [11:0]                    sar_data,
  output logic                                conversion_clock,
  output adc_conv_pkg::analog_ctrl_type       analog_ctrl,
  output logic                                irq
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic                   awv;
    logic [9:0]             awidx;
    logic                   wv;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [7:0]             cfg;
    logic [7:0]             acc_cfg;
    logic [1:0]             ctrl;
    logic                   done;
    logic                   irq_en;
    logic [2:0]             lp_sync;
    logic [4:0]             div_cnt;
    logic                   conv_tick;
    adc_conv_pkg::phase_type phase;
    logic [1:0]             trk_cnt;
    logic [6:0]             burst_cnt;
    logic                   sar_start;
    logic [15:0]            acc;
  } state_type;

  state_type st_reg;
  state_type st_next;

  logic        src_tick;
  logic        soc;
  logic        delayed;
  logic        burst;
  logic [15:0] sample;
  logic [15:0] result_fmt;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        wr_hit;
  logic        wr_fire;
  logic        conv_end;
  logic        burst_last;
  logic [4:0]  div_field;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings
  assign div_field  = st_reg.cfg[adc_conv_pkg::CFG_DIV_LSB +: 5];
  assign delayed    = st_reg.cfg[adc_conv_pkg::CFG_DELAYED];
  assign burst      = st_reg.ctrl[adc_conv_pkg::CTRL_BURST];
  assign conv_end   = (st_reg.phase == adc_conv_pkg::PH_CONVERT) && sar_done;
  assign burst_last = st_reg.burst_cnt ==
                      adc_conv_pkg::repeat_total(st_reg.acc_cfg[adc_conv_pkg::ACC_RPT_LSB +: 3]) - 7'h01;
  // Burst pulls the divider onto rising oscillator edges, else every aclk
  assign src_tick = burst ? (st_reg.lp_sync[1] & ~st_reg.lp_sync[2]) : 1'b1;
  assign wr_fire  = st_reg.awv && st_reg.wv && !st_reg.bvalid;
  assign soc = (st_reg.phase == adc_conv_pkg::PH_IDLE) && st_reg.ctrl[adc_conv_pkg::CTRL_EN] &&
               (start_trigger || (wr_fire && st_reg.awidx == adc_conv_pkg::IDX_CTRL &&
                                  st_reg.wstrb[0] && st_reg.wdata[adc_conv_pkg::CTRL_START]));

  // Sample width follows the resolution bits; twelve-bit wins over eight
  always_comb begin
    if (st_reg.acc_cfg[adc_conv_pkg::ACC_TWELVE]) begin
      sample = {4'h0, sar_data};
    end else if (st_reg.cfg[adc_conv_pkg::CFG_EIGHT_BIT]) begin
      sample = {8'h00, sar_data[7:0]};
    end else begin
      sample = {6'h00, sar_data[9:0]};
    end
  end

  // Read formatting of the accumulator
  always_comb begin
    unique case (st_reg.acc_cfg[adc_conv_pkg::ACC_SJ_LSB +: 3])
      3'h1: result_fmt = st_reg.acc >> 1;
      3'h2, 3'h3: result_fmt = st_reg.acc >> 2;
      3'h4: begin
        if (st_reg.acc_cfg[adc_conv_pkg::ACC_TWELVE]) begin
          result_fmt = st_reg.acc << 4;
        end else if (st_reg.cfg[adc_conv_pkg::CFG_EIGHT_BIT]) begin
          result_fmt = st_reg.acc << 8;
        end else begin
          result_fmt = st_reg.acc << 6;
        end
      end
      default: result_fmt = st_reg.acc;
    endcase
  end

  // Read mux; accumulate enable is masked out of the readback
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr[11:2])
      adc_conv_pkg::IDX_ACC_CFG: rd_val[7:0] = st_reg.acc_cfg & ~(8'h01 << adc_conv_pkg::ACC_AE);
      adc_conv_pkg::IDX_CFG:     rd_val[7:0] = st_reg.cfg;
      adc_conv_pkg::IDX_CTRL:    rd_val[1:0] = st_reg.ctrl;
      adc_conv_pkg::IDX_STATUS:  rd_val[0]   = st_reg.done;
      adc_conv_pkg::IDX_CLEAR:   rd_val      = 32'h0000_0000;
      adc_conv_pkg::IDX_IRQ_EN:  rd_val[0]   = st_reg.irq_en;
      adc_conv_pkg::IDX_RESULT:  rd_val[15:0] = result_fmt;
      default:                   rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    unique case (st_reg.awidx)
      adc_conv_pkg::IDX_ACC_CFG, adc_conv_pkg::IDX_CFG, adc_conv_pkg::IDX_CTRL,
      adc_conv_pkg::IDX_CLEAR, adc_conv_pkg::IDX_IRQ_EN, adc_conv_pkg::IDX_RESULT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for bus, registers, divider, sequencer and accumulator
  always_comb begin
    st_next = st_reg;
    st_next.lp_sync = {st_reg.lp_sync[1:0], lp_osc_pin};
    // Write channels are taken independently, answered once both are held
    if (s_axi_awvalid && !st_reg.awv) begin
      st_next.awv   = 1'b1;
      st_next.awidx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && !st_reg.wv) begin
      st_next.wv    = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_next.awv    = 1'b0;
      st_next.wv     = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = wr_hit ? adc_conv_pkg::RESP_OKAY : adc_conv_pkg::RESP_SLVERR;
      if (st_reg.wstrb[0]) begin
        unique case (st_reg.awidx)
          adc_conv_pkg::IDX_ACC_CFG: st_next.acc_cfg = st_reg.wdata[7:0];
          adc_conv_pkg::IDX_CFG:     st_next.cfg = st_reg.wdata[7:0];
          adc_conv_pkg::IDX_CTRL:    st_next.ctrl = st_reg.wdata[1:0];
          adc_conv_pkg::IDX_IRQ_EN:  st_next.irq_en = st_reg.wdata[0];
          adc_conv_pkg::IDX_RESULT:  st_next.acc[7:0] = st_reg.wdata[7:0];
          default: ;
        endcase
      end
      if (st_reg.wstrb[1] && st_reg.awidx == adc_conv_pkg::IDX_RESULT) begin
        st_next.acc[15:8] = st_reg.wdata[15:8];
      end
    end
    // Read answers one cycle after the address is taken
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_val;
      st_next.rresp  = rd_hit ? adc_conv_pkg::RESP_OKAY : adc_conv_pkg::RESP_SLVERR;
    end
    // Divide the source by field plus one
    st_next.conv_tick = 1'b0;
    if (src_tick) begin
      if (st_reg.div_cnt >= div_field) begin
        st_next.div_cnt   = 5'h00;
        st_next.conv_tick = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 5'h01;
      end
    end
    // Sequencer
    st_next.sar_start = 1'b0;
    unique case (st_reg.phase)
      adc_conv_pkg::PH_IDLE: begin
        if (soc) begin
          st_next.burst_cnt = 7'h00;
          st_next.trk_cnt   = 2'h0;
          if (burst) begin
            st_next.acc = 16'h0000;
          end
          if (delayed) begin
            st_next.phase = adc_conv_pkg::PH_TRACK;
          end else begin
            st_next.phase     = adc_conv_pkg::PH_CONVERT;
            st_next.sar_start = 1'b1;
          end
        end
      end
      adc_conv_pkg::PH_TRACK: begin
        if (st_reg.conv_tick) begin
          st_next.trk_cnt = st_reg.trk_cnt + 2'h1;
          if (st_reg.trk_cnt == adc_conv_pkg::TRACK_CYCLES - 2'h1) begin
            st_next.phase     = adc_conv_pkg::PH_CONVERT;
            st_next.sar_start = 1'b1;
          end
        end
      end
      adc_conv_pkg::PH_CONVERT: begin
        if (sar_done) begin
          st_next.trk_cnt = 2'h0;
          if (burst) begin
            st_next.acc       = st_reg.acc + sample;
            st_next.burst_cnt = st_reg.burst_cnt + 7'h01;
            if (burst_last) begin
              st_next.phase = adc_conv_pkg::PH_IDLE;
            end else if (delayed) begin
              st_next.phase = adc_conv_pkg::PH_TRACK;
            end else begin
              st_next.sar_start = 1'b1;
            end
          end else begin
            st_next.phase = adc_conv_pkg::PH_IDLE;
            st_next.acc = st_reg.acc_cfg[adc_conv_pkg::ACC_AE] ? st_reg.acc + sample : sample;
          end
        end
      end
    endcase
    // Done flag: a completion in the clearing cycle still sets it
    if (wr_fire && st_reg.wstrb[0] && st_reg.awidx == adc_conv_pkg::IDX_CLEAR && st_reg.wdata[0]) begin
      st_next.done = 1'b0;
    end
    if (conv_end && (!burst || burst_last)) begin
      st_next.done = 1'b1;
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg         <= '0;
      st_reg.cfg     <= adc_conv_pkg::CFG_RESET;
      st_reg.acc_cfg <= adc_conv_pkg::ACC_CFG_RESET;
      st_reg.ctrl    <= adc_conv_pkg::CTRL_RESET;
      st_reg.phase   <= adc_conv_pkg::PH_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready    = !st_reg.awv;
  assign s_axi_wready     = !st_reg.wv;
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_arready    = !st_reg.rvalid;
  assign s_axi_rvalid     = st_reg.rvalid;
  assign s_axi_rdata      = st_reg.rdata;
  assign s_axi_rresp      = st_reg.rresp;
  assign sar_start        = st_reg.sar_start;
  assign conversion_clock = st_reg.conv_tick;
  assign irq              = st_reg.done && st_reg.irq_en;
  // One driver for the whole struct, so no member is written by two assigns
  always_comb begin
    analog_ctrl.eight_bit_mode_enable  = st_reg.cfg[adc_conv_pkg::CFG_EIGHT_BIT];
    analog_ctrl.twelve_bit_mode_enable = st_reg.acc_cfg[adc_conv_pkg::ACC_TWELVE];
    analog_ctrl.input_gain_select      = st_reg.cfg[adc_conv_pkg::CFG_GAIN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_div_period;
    st_reg.conv_tick && !$past(st_reg.conv_tick) |-> $past(st_reg.div_cnt) >= $past(div_field);
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider tick early");

  property p_burst_source;
    burst && !(st_reg.lp_sync[1] && !st_reg.lp_sync[2]) |=> $stable(st_reg.div_cnt) && !st_reg.conv_tick;
  endproperty
  a_burst_source: assert property (p_burst_source) else $error("divider ran without oscillator edge");

  property p_normal_start;
    soc && !delayed |=> st_reg.phase == adc_conv_pkg::PH_CONVERT && st_reg.sar_start;
  endproperty
  a_normal_start: assert property (p_normal_start) else $error("normal track start delayed");

  property p_delayed_start;
    soc && delayed |=> st_reg.phase == adc_conv_pkg::PH_TRACK && !st_reg.sar_start;
  endproperty
  a_delayed_start: assert property (p_delayed_start) else $error("delayed track skipped");

  property p_latest_only;
    conv_end && !burst && !st_reg.acc_cfg[adc_conv_pkg::ACC_AE] && !wr_fire |=> st_reg.acc == $past(sample);
  endproperty
  a_latest_only: assert property (p_latest_only) else $error("result not latest sample");

  property p_burst_count;
    conv_end && burst && burst_last |=> st_reg.phase == adc_conv_pkg::PH_IDLE && st_reg.done;
  endproperty
  a_burst_count: assert property (p_burst_count) else $error("burst did not end on count");

  property p_done_sticky;
    st_reg.done && !(wr_fire && st_reg.awidx == adc_conv_pkg::IDX_CLEAR) |=> st_reg.done;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped");

  property p_reserved_fmt;
    st_reg.acc_cfg[adc_conv_pkg::ACC_SJ_LSB +: 3] > 3'h4 |-> result_fmt == st_reg.acc;
  endproperty
  a_reserved_fmt: assert property (p_reserved_fmt) else $error("reserved format shifted");

  c_burst_done: cover property (conv_end && burst && burst_last);
  c_delayed: cover property (st_reg.phase == adc_conv_pkg::PH_TRACK ##[1:200] st_reg.sar_start);
  c_irq: cover property (irq);
endmodule // adc_conv_ctrl
`default_nettype wire

//--- design/adc_conv_pkg.sv
/*
  Constants, carrier structs and helpers for the ADC conversion configuration
  and accumulator block. Assumes an AXI4-Lite master with 32-bit data and a
  SAR core that answers a start pulse with a done pulse and right-aligned data.
*/
// Contract
// - Conversion clock is source clock divided by divider field bits 7:3 plus one.
// - Divider source is system clock with burst off, low-power oscillator with burst on.
// - Eight-bit enable bit 2 clear gives 10-bit mode, set gives 8-bit results.
// - Normal track mode starts conversion right after start event, no extra tracking.
// - Delayed track mode tracks three conversion clocks after start, then converts.
// - Gain select clear gives gain 0.5, set gives gain 1.
// - Accumulator config bit 7 enables 12-bit conversion mode.
// - Burst off: accumulate enable keeps running sum, else only latest result.
// - Accumulate enable bit 6 is write-only and always reads zero.
// - Shift/justify: 000 none, 001 right one, 01x right two, 100 left justify.
// - Repeat count sets burst conversions: 1, 4, 8, 16, 32, 64.
// - Done flag sets after one conversion, or whole burst; software clears it.
// - Burst with delayed tracking inserts three conversion clocks before each conversion.
`default_nettype none
package adc_conv_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_ACC_CFG = 10'h0ba;
  localparam logic [9:0] IDX_CFG     = 10'h0bc;
  localparam logic [9:0] IDX_CTRL    = 10'h0c0;
  localparam logic [9:0] IDX_STATUS  = 10'h0c1;
  localparam logic [9:0] IDX_CLEAR   = 10'h0c2;
  localparam logic [9:0] IDX_IRQ_EN  = 10'h0c3;
  localparam logic [9:0] IDX_RESULT  = 10'h0c4;
  // Field positions
  localparam int CFG_DIV_LSB   = 3;
  localparam int CFG_EIGHT_BIT = 2;
  localparam int CFG_DELAYED   = 1;
  localparam int CFG_GAIN      = 0;
  localparam int ACC_TWELVE    = 7;
  localparam int ACC_AE        = 6;
  localparam int ACC_SJ_LSB    = 3;
  localparam int ACC_RPT_LSB   = 0;
  localparam int CTRL_EN       = 0;
  localparam int CTRL_BURST    = 1;
  localparam int CTRL_START    = 2;
  // Reset values
  localparam logic [7:0] CFG_RESET     = 8'hf8;
  localparam logic [7:0] ACC_CFG_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET    = 2'h0;
  // Tracking length in conversion-clock cycles
  localparam logic [1:0] TRACK_CYCLES  = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b001,
    PH_TRACK   = 3'b010,
    PH_CONVERT = 3'b100
  } phase_type;
  // Static settings handed to the analog front end
  typedef struct packed {
    logic eight_bit_mode_enable;
    logic twelve_bit_mode_enable;
    logic input_gain_select;
  } analog_ctrl_type;
  // Burst length for a repeat code; reserved codes fall back to one
  function automatic logic [6:0] repeat_total(input logic [2:0] code);
    case (code)
      3'h1: repeat_total = 7'h04;
      3'h2: repeat_total = 7'h08;
      3'h3: repeat_total = 7'h10;
      3'h4: repeat_total = 7'h20;
      3'h5: repeat_total = 7'h40;
      default: repeat_total = 7'h01;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- sim/adc_conv_ctrl_tb.sv
/*
  Self-checking bench for adc_conv_ctrl: registers, divider, tracking,
  accumulation, justify formatting, burst repeat and the done interrupt.
  Assumes adc_conv_pkg and adc_conv_ctrl are compiled before this file.
*/
`default_nettype none
module adc_conv_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_ACC  = {adc_conv_pkg::IDX_ACC_CFG, 2'b00};
  localparam logic [11:0] A_CFG  = {adc_conv_pkg::IDX_CFG, 2'b00};
  localparam logic [11:0] A_CTRL = {adc_conv_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {adc_conv_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_CLR  = {adc_conv_pkg::IDX_CLEAR, 2'b00};
  localparam logic [11:0] A_IEN  = {adc_conv_pkg::IDX_IRQ_EN, 2'b00};
  localparam logic [11:0] A_RES  = {adc_conv_pkg::IDX_RESULT, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h2ec;
  localparam logic [1:0]  OK     = adc_conv_pkg::RESP_OKAY;
  logic                           aclk = 1'b0;
  logic                           aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                           arvalid, arready, rvalid, rready, lp_osc, start_trigger;
  logic                           sar_start, sar_done, conversion_clock, irq;
  logic [11:0]                    awaddr, araddr, sar_data;
  logic [31:0]                    wdata, rdata;
  logic [3:0]                     wstrb;
  logic [1:0]                     bresp, rresp;
  adc_conv_pkg::analog_ctrl_type  actl;
  int                             bad_count = 0;
  int                             comparisons = 0;
  int                             cycles = 0;

  adc_conv_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lp_osc_pin(lp_osc),
    .start_trigger(start_trigger), .sar_start(sar_start), .sar_done(sar_done), .sar_data(sar_data),
    .conversion_clock(conversion_clock), .analog_ctrl(actl), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // System clock, and a slow oscillator kept off the clock edges
  always #4 aclk = ~aclk;
  initial begin
    lp_osc = 1'b0;
    #3;
    forever #24 lp_osc = ~lp_osc;
  end

  // Hang guard; generous against a run of a few thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, so the rising edge only drives
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, aw_done, w_done, b_hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_hit = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge aclk);
      if (aw_hit) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!b_hit) begin
      @(negedge aclk);
      b_hit = bvalid;
      @(posedge aclk);
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    logic hit;
    hit = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit) begin
      @(negedge aclk);
      hit = arvalid && arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = rvalid;
      d = rdata;
      @(posedge aclk);
    end
    rready <= 1'b0;
    chk(32'(rresp), 32'(er), "rresp");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Cycles between two divider pulses
  task automatic gap(output int n);
    n = 0;
    @(negedge aclk);
    while (conversion_clock !== 1'b1) @(negedge aclk);
    do begin
      @(negedge aclk);
      n++;
    end while (conversion_clock !== 1'b1);
  endtask

  task automatic trig();
    @(posedge aclk);
    start_trigger <= 1'b1;
    @(posedge aclk);
    start_trigger <= 1'b0;
  endtask

  // Stands in for the SAR core: waits for a start, answers with one result
  task automatic conv(input logic [11:0] v, output int lat, output int pulses);
    lat = 0;
    pulses = 0;
    @(negedge aclk);
    while (sar_start !== 1'b1) begin
      pulses += int'(conversion_clock === 1'b1);
      lat++;
      @(negedge aclk);
    end
    @(posedge aclk);
    sar_done <= 1'b1;
    sar_data <= v;
    @(posedge aclk);
    sar_done <= 1'b0;
    sar_data <= 12'($urandom);
  endtask

  // Read-back format of the accumulator for a justify code and a width
  function automatic logic [15:0] fmt(input logic [15:0] acc, input logic [2:0] sj, input int w);
    case (sj)
      3'h1: fmt = acc >> 1;
      3'h2, 3'h3: fmt = acc >> 2;
      3'h4: fmt = acc << (16 - w);
      default: fmt = acc;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [15:0] exp;
    logic [11:0] v;
    logic [7:0]  c;
    int          n, lat, p, dv, seed;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, start_trigger, sar_done} = '0;
    {awaddr, araddr, sar_data, wdata} = '0;
    wstrb = 4'hf;
    seed = $urandom(3);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CFG, OK, d);
    chk(32'(d[7:0]), 32'h0000_00f8, "cfg reset");
    rd(A_ACC, OK, d);
    chk(32'(d[7:0]), 32'h0, "acc cfg reset");
    chk(32'(actl), 32'h0, "analog reset");
    rd(A_BAD, adc_conv_pkg::RESP_SLVERR, d);
    wr(A_BAD, 32'hffff_ffff, adc_conv_pkg::RESP_SLVERR);
    // Byte lanes: lane 0 off leaves byte registers alone, lane 1 sets the high byte
    wstrb <= 4'h2;
    wr(A_CFG, 32'h0, OK);
    wr(A_RES, 32'h0000_abcd, OK);
    wstrb <= 4'hf;
    rd(A_CFG, OK, d);
    chk(32'(d[7:0]), 32'h0000_00f8, "cfg kept without lane 0");
    rd(A_RES, OK, d);
    chk(32'(d[15:0]), 32'h0000_ab00, "result high lane");
    // Static analog settings follow the register bits
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom);
      wr(A_CFG, 32'(c), OK);
      rd(A_CFG, OK, d);
      chk(32'(d[7:0]), 32'(c), "cfg readback");
      chk(32'(actl.eight_bit_mode_enable), 32'(c[2]), "eight bit");
      chk(32'(actl.input_gain_select), 32'(c[0]), "gain");
    end
    wr(A_ACC, 32'h0000_00c0, OK);
    rd(A_ACC, OK, d);
    chk(32'(d[7:0]), 32'h0000_0080, "accumulate bit reads zero");
    chk(32'(actl.twelve_bit_mode_enable), 32'h1, "twelve bit");
    wr(A_ACC, 32'h0, OK);
    // Divider from system clock, then from the slow oscillator in burst
    for (int b = 0; b < 2; b++) begin
      dv = $urandom_range(0, 3);
      wr(A_CFG, 32'(dv << 3), OK);
      wr(A_CTRL, 32'(1 + 2 * b), OK);
      gap(n);
      gap(n);
      chk(32'(n), 32'((dv + 1) * (b ? 6 : 1)), "divider period");
    end
    // Single conversions: normal or delayed, latest or running sum
    wr(A_CTRL, 32'h1, OK);
    wr(A_IEN, 32'h1, OK);
    for (int k = 0; k < 4; k++) begin
      wr(A_CFG, 32'h0000_0038 | 32'((k & 1) << 1), OK);
      wr(A_ACC, 32'((k & 2) << 5), OK);
      wr(A_RES, 32'h0, OK);
      wr(A_CLR, 32'h1, OK);
      exp = 16'h0;
      for (int j = 0; j < 3; j++) begin
        v = 12'($urandom_range(0, 1023));
        if (k[0] && j == 2) wr(A_CTRL, 32'h5, OK);
        else trig();
        conv(v, lat, p);
        if (!(k[0] && j == 2)) chk(32'(k[0] ? p : int'(lat == 0)), k[0] ? 32'h3 : 32'h1, "tracking");
        exp = k[1] ? exp + 16'(v) : 16'(v);
        rd(A_STAT, OK, d);
        chk(32'(d[0]), 32'h1, "done after single");
        chk(32'(irq), 32'h1, "irq raised");
        rd(A_RES, OK, d);
        chk(32'(d[15:0]), 32'(exp), "result");
      end
      wr(A_IEN, 32'h0, OK);
      chk(32'(irq), 32'h0, "irq masked");
      wr(A_CLR, 32'h1, OK);
      rd(A_STAT, OK, d);
      chk(32'(d[0]), 32'h0, "done cleared");
      wr(A_IEN, 32'h1, OK);
    end
    // Justify codes in 10-, 12- and 8-bit modes
    for (int m = 0; m < 3; m++) begin
      n = (m == 0) ? 10 : (m == 1) ? 12 : 8;
      wr(A_CFG, (m == 2) ? 32'h0000_000c : 32'h0000_0008, OK);
      // A real conversion in this width: the sample is cut to n bits
      wr(A_ACC, (m == 1) ? 32'h0000_0080 : 32'h0, OK);
      v = 12'($urandom);
      trig();
      conv(v, lat, p);
      rd(A_RES, OK, d);
      chk(32'(d[15:0]), 32'(v) & ((32'h1 << n) - 32'h1), "sample width");
      exp = 16'($urandom_range(0, (1 << n) - 1));
      wr(A_RES, 32'(exp), OK);
      for (int sj = 0; sj < 8; sj++) begin
        wr(A_ACC, 32'(((m == 1) ? 128 : 0) + (sj << 3)), OK);
        rd(A_RES, OK, d);
        chk(32'(d[15:0]), 32'(fmt(exp, 3'(sj), n)), "justify");
      end
    end
    // Repeat codes 0 to 5 in burst; odd codes with delayed tracking
    for (int code = 0; code < 6; code++) begin
      n = (code == 0) ? 1 : (2 << code);
      wr(A_CFG, 32'h0000_0008 | 32'((code & 1) << 1), OK);
      wr(A_ACC, 32'(code), OK);
      wr(A_CTRL, 32'h3, OK);
      wr(A_CLR, 32'h1, OK);
      trig();
      exp = 16'h0;
      for (int i = 0; i < n; i++) begin
        // Look after the launching edge has settled, before the next falling edge
        #1 chk(32'(irq), 32'h0, "no done mid burst");
        v = 12'($urandom_range(0, 1023));
        conv(v, lat, p);
        if (code & 1) chk(32'(p), 32'h3, "burst tracking");
        exp = exp + 16'(v);
      end
      repeat (2) @(negedge aclk);
      chk(32'(irq), 32'h1, "done after burst");
      rd(A_RES, OK, d);
      chk(32'(d[15:0]), 32'(exp), "burst sum");
    end
    wr(A_ACC, 32'h0, OK);
    wr(A_CTRL, 32'h1, OK);
    report_and_stop();
  end
endmodule // adc_conv_ctrl_tb
`default_nettype wire
